// ==== logic/scpc_pkg.sv ====
// Package with register map, field layout, reset values and timing for the sample clock control block.
package scpc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CFG_ONE   = 8'h00;
    localparam logic [7:0] IDX_CFG_THREE = 8'h02;
    localparam logic [7:0] IDX_CFG_FOUR  = 8'h03;
    localparam logic [7:0] IDX_STATUS    = 8'h1b;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h1c;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h1d;

    // Field positions.
    localparam int BIT_VCO_CAL     = 24;
    localparam int BIT_DAC_CAL     = 24;
    localparam int BIT_LOCK        = 24;
    localparam int BIT_VCO_BUSY    = 25;
    localparam int BIT_DAC_BUSY    = 26;
    localparam int BIT_PLL_EN      = 18;
    localparam int FB_DIV_LSB      = 8;
    localparam int FB_DIV_MSB      = 15;
    localparam int BIT_CP_MANUAL   = 6;
    localparam int CP_CODE_LSB     = 3;
    localparam int CP_CODE_MSB     = 5;
    localparam int AUTO_CODE_LSB   = 0;
    localparam int AUTO_CODE_MSB   = 2;

    // Interrupt status bits.
    localparam int IRQ_W        = 3;
    localparam int IRQ_VCO_DONE = 0;
    localparam int IRQ_DAC_DONE = 1;
    localparam int IRQ_LOCK_CHG = 2;

    // Reset values and limits.
    localparam logic [7:0]  FB_DIV_RST  = 8'h14;
    localparam logic [7:0]  FB_DIV_MIN  = 8'h0a;
    localparam logic [2:0]  CP_CODE_RST = 3'h3;
    localparam logic [9:0]  CP_STEP_UA  = 10'h07d;

    // Recommended charge pump code by divide range upper bounds.
    localparam logic [7:0] N_UP_0 = 8'h0f;
    localparam logic [7:0] N_UP_1 = 8'h17;
    localparam logic [7:0] N_UP_2 = 8'h23;
    localparam logic [7:0] N_UP_3 = 8'h2b;
    localparam logic [7:0] N_UP_4 = 8'h37;
    localparam logic [7:0] N_UP_5 = 8'h3f;
    localparam logic [7:0] N_UP_6 = 8'h4f;

    // Timing in sample clock periods.
    localparam int DAC_CAL_PERIODS = 469632;
    localparam int VCO_CAL_PERIODS = 1024;

    // Calibration sequencer states, Gray along idle, VCO, DAC.
    typedef enum logic [1:0] {
        SCPC_IDLE = 2'b00,
        SCPC_VCO  = 2'b01,
        SCPC_DAC  = 2'b11
    } scpc_state_t;

endpackage : scpc_pkg

// ==== logic/scpc_timer.sv ====
// One-shot cycle timer used for the calibration intervals.
`timescale 1ns/100ps
module scpc_timer #(
    parameter int WIDTH = 20,
    parameter int COUNT = 16
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    logic [WIDTH-1:0] count;

    // Loads on start, counts down, and pulses done for one cycle, in the first cycle after busy falls.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= WIDTH'(COUNT - 1);
                busy  <= 1'b1;
            end else if (busy) begin
                if (count == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - WIDTH'(1);
                end
            end
        end
    end

endmodule : scpc_timer

// ==== logic/scpc_clock_control.sv ====
// Sample clock source select, PLL divide and charge pump control, calibration sequencing, AHB-Lite registers.
//
// Requirements on this block and on the host that drives it
// RQ1 - Sample clock comes from PLL when select bit set, else reference pins.
// RQ2 - In direct mode the outside source supplies sample clock up to 3.5 GHz.
// RQ3 - PLL multiplies only by even factors from 20 to 510.
// RQ4 - Feedback divide is bits 15:8 of config register three, valid 10 to 255.
// RQ5 - Host never programs a feedback divide below ten.
// RQ6 - Total multiplication equals twice the feedback divide value.
// RQ7 - Without manual override, charge pump current is chosen by VCO calibration.
// RQ8 - Manual override bit 6 selects the programmed 3-bit current code.
// RQ9 - Current is 125 uA per step plus 125; code 011 by default.
// RQ10 - Host picks current by divide range, 125 uA up to 1000 uA.
// RQ11 - Host starts VCO calibration with bit 24 of register one once reference stable.
// RQ12 - Host clears trigger bit before each later VCO calibration.
// RQ13 - Host finishes VCO calibration before starting DAC calibration.
// RQ14 - Status bit 24 of register 0x1B reads one when PLL in use and locked.
// RQ15 - Host keeps PLL output between 2.4 and 2.5 GHz.
// RQ16 - Host sets then clears DAC calibration bit after power-up or clock change.
// RQ17 - DAC calibration lasts 469,632 sample clock periods.
// RQ18 - Lock status is read-only; writes to it change nothing.
// RQ19 - Calibration busy shows from trigger edge until VCO calibration ends.
`timescale 1ns/100ps
module scpc_clock_control
    import scpc_pkg::*;
#(
    parameter int DAC_CAL_CYCLES = scpc_pkg::DAC_CAL_PERIODS,
    parameter int VCO_CAL_CYCLES = scpc_pkg::VCO_CAL_PERIODS
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        pll_lock_raw,
    output logic             sample_clock_from_pll,
    output logic      [7:0]  fb_divide,
    output logic      [8:0]  pll_multiply,
    output logic      [2:0]  cp_code,
    output logic      [9:0]  charge_pump_current,
    output logic             vco_cal_busy,
    output logic             dac_cal_busy,
    output logic             irq
);
    import scpc_pkg::*;

    logic        rst_meta_b;
    logic        rst_sync_b;
    logic        lock_meta;
    logic        lock_sync;
    logic        lock_prev;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_idx;
    logic        vco_trig;
    logic        vco_trig_prev;
    logic        pll_en;
    logic [7:0]  fb_div_raw;
    logic        cp_manual;
    logic [2:0]  cp_prog;
    logic [2:0]  cp_auto;
    logic        dac_trig;
    logic        dac_trig_prev;
    logic        dac_pend;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic        accept;
    logic        wr_en;
    logic        vco_rise;
    logic        dac_rise;
    logic        vco_start;
    logic        dac_start;
    logic        vco_done;
    logic        dac_done;
    logic        lock_status;
    logic [7:0]  fb_eff;
    logic [2:0]  cp_eff;
    logic [2:0]  recommended_code;
    logic [31:0] rdata;
    scpc_state_t state;
    scpc_state_t next_state;

    // Reset is released through two flops so every flop reset by rst_sync_b leaves reset on the same edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // The lock detector is analogue and asynchronous, so it is synchronised first.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            lock_prev <= 1'b0;
        end else begin
            lock_meta <= pll_lock_raw;
            lock_sync <= lock_meta;
            lock_prev <= lock_sync;
        end
    end

    // Bus address phase is taken only while the bus is ready.
    assign accept = hsel && hready && htrans[1];
    assign wr_en  = dp_valid && dp_write && hready;

    // Data phase bookkeeping and the one-wait-state read answer.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dp_valid  <= 1'b0;
            dp_write  <= 1'b0;
            dp_idx    <= '0;
            hreadyout <= 1'b1;
            hrdata    <= '0;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (hready) begin
                dp_valid <= accept;
                dp_write <= hwrite;
                dp_idx   <= haddr[9:2];
                // A read waits one cycle so it sees a write made just before it.
                hreadyout <= !(accept && !hwrite);
            end else if (dp_valid && !dp_write && !hreadyout) begin
                hrdata    <= rdata;
                hreadyout <= 1'b1;
            end
        end
    end

    // Software writable configuration fields.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            vco_trig   <= 1'b0;
            pll_en     <= 1'b0;
            fb_div_raw <= FB_DIV_RST;
            cp_manual  <= 1'b0;
            cp_prog    <= CP_CODE_RST;                                        // RQ9
            dac_trig   <= 1'b0;
            irq_mask   <= '0;
        end else if (wr_en) begin
            case (dp_idx)
                IDX_CFG_ONE: begin
                    vco_trig <= hwdata[BIT_VCO_CAL];                          // RQ11
                end
                IDX_CFG_THREE: begin
                    pll_en     <= hwdata[BIT_PLL_EN];
                    fb_div_raw <= hwdata[FB_DIV_MSB:FB_DIV_LSB];              // RQ4
                    cp_manual  <= hwdata[BIT_CP_MANUAL];                      // RQ8
                    cp_prog    <= hwdata[CP_CODE_MSB:CP_CODE_LSB];
                end
                IDX_CFG_FOUR: begin
                    dac_trig <= hwdata[BIT_DAC_CAL];
                end
                IDX_IRQ_MASK: begin
                    irq_mask <= hwdata[IRQ_W-1:0];
                end
                // The status word is read-only and unmapped writes are dropped.
                default: begin                                                // RQ18
                end
            endcase
        end
    end

    // Trigger bits act on their cleared-to-set edge only.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            vco_trig_prev <= 1'b0;
            dac_trig_prev <= 1'b0;
        end else begin
            vco_trig_prev <= vco_trig;
            dac_trig_prev <= dac_trig;
        end
    end

    assign vco_rise = vco_trig && !vco_trig_prev;                             // RQ12
    assign dac_rise = dac_trig && !dac_trig_prev;

    // A divide below the legal minimum is raised to it, keeping the factor in 20 to 510.
    assign fb_eff = (fb_div_raw < FB_DIV_MIN) ? FB_DIV_MIN : fb_div_raw;      // RQ3

    // Recommended current code by divide range, as chosen by calibration.
    always_comb begin
        if (fb_eff <= N_UP_0) begin
            recommended_code = 3'h0;
        end else if (fb_eff <= N_UP_1) begin
            recommended_code = 3'h1;
        end else if (fb_eff <= N_UP_2) begin
            recommended_code = 3'h2;
        end else if (fb_eff <= N_UP_3) begin
            recommended_code = 3'h3;
        end else if (fb_eff <= N_UP_4) begin
            recommended_code = 3'h4;
        end else if (fb_eff <= N_UP_5) begin
            recommended_code = 3'h5;
        end else if (fb_eff <= N_UP_6) begin
            recommended_code = 3'h6;
        end else begin
            recommended_code = 3'h7;
        end
    end

    // Calibration sequencer; a DAC request during VCO calibration is held until it ends.
    always_comb begin
        next_state = state;
        vco_start  = 1'b0;
        dac_start  = 1'b0;
        case (state)
            SCPC_IDLE: begin
                if (vco_rise && pll_en) begin
                    next_state = SCPC_VCO;
                    vco_start  = 1'b1;
                end else if (dac_rise) begin
                    next_state = SCPC_DAC;
                    dac_start  = 1'b1;
                end
            end
            SCPC_VCO: begin
                if (vco_done && (dac_pend || dac_rise)) begin                 // RQ13
                    next_state = SCPC_DAC;
                    dac_start  = 1'b1;
                end else if (vco_done) begin
                    next_state = SCPC_IDLE;
                end
            end
            SCPC_DAC: begin
                if (dac_done) begin
                    next_state = SCPC_IDLE;
                end
            end
            default: begin
                next_state = SCPC_IDLE;
            end
        endcase
    end

    // State, held DAC request and the automatically chosen current code.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state    <= SCPC_IDLE;
            dac_pend <= 1'b0;
            cp_auto  <= CP_CODE_RST;
        end else begin
            state <= next_state;
            if (state == SCPC_VCO && dac_rise && !vco_done) begin
                dac_pend <= 1'b1;
            end else if (dac_start) begin
                dac_pend <= 1'b0;
            end
            if (vco_done) begin
                cp_auto <= recommended_code;                                  // RQ7
            end
        end
    end

    scpc_timer #(
        .WIDTH ($clog2(VCO_CAL_CYCLES + 1)),
        .COUNT (VCO_CAL_CYCLES)
    ) u_vco_timer (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .start (vco_start),
        .busy  (),
        .done  (vco_done)
    );

    scpc_timer #(
        .WIDTH ($clog2(DAC_CAL_CYCLES + 1)),
        .COUNT (DAC_CAL_CYCLES)
    ) u_dac_timer (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .start (dac_start),                                                   // RQ17
        .busy  (),
        .done  (dac_done)
    );

    // Lock only means anything while the PLL is the source.
    assign lock_status = lock_sync && pll_en;                                 // RQ14
    assign cp_eff      = cp_manual ? cp_prog : cp_auto;                       // RQ8

    // Interrupt events; a set in the same cycle as a clear wins.
    assign irq_set[IRQ_VCO_DONE] = vco_done;
    assign irq_set[IRQ_DAC_DONE] = dac_done;
    assign irq_set[IRQ_LOCK_CHG] = lock_sync ^ lock_prev;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            if (wr_en && dp_idx == IDX_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~hwdata[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Control outputs, all registered.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sample_clock_from_pll <= 1'b0;
            fb_divide             <= FB_DIV_RST;
            pll_multiply          <= {FB_DIV_RST, 1'b0};
            cp_code               <= CP_CODE_RST;
            charge_pump_current   <= 10'(CP_STEP_UA * 10'(CP_CODE_RST + 4'h1));
            vco_cal_busy          <= 1'b0;
            dac_cal_busy          <= 1'b0;
        end else begin
            sample_clock_from_pll <= pll_en;                                  // RQ1
            fb_divide             <= fb_eff;
            pll_multiply          <= {fb_eff, 1'b0};                          // RQ6
            cp_code               <= cp_eff;
            charge_pump_current   <= 10'(CP_STEP_UA * 10'({1'b0, cp_eff} + 4'h1)); // RQ9
            vco_cal_busy          <= (next_state == SCPC_VCO);                // RQ19
            dac_cal_busy          <= (next_state == SCPC_DAC);
        end
    end

    // Read data; reserved bits read as zero.
    always_comb begin
        rdata = '0;
        case (dp_idx)
            IDX_CFG_ONE: begin
                rdata[BIT_VCO_CAL] = vco_trig;
            end
            IDX_CFG_THREE: begin
                rdata[BIT_PLL_EN]              = pll_en;
                rdata[FB_DIV_MSB:FB_DIV_LSB]   = fb_div_raw;
                rdata[BIT_CP_MANUAL]           = cp_manual;
                rdata[CP_CODE_MSB:CP_CODE_LSB] = cp_prog;
            end
            IDX_CFG_FOUR: begin
                rdata[BIT_DAC_CAL] = dac_trig;
            end
            IDX_STATUS: begin
                rdata[BIT_LOCK]                    = lock_status;             // RQ14
                rdata[BIT_VCO_BUSY]                = (state == SCPC_VCO);
                rdata[BIT_DAC_BUSY]                = (state == SCPC_DAC);
                rdata[AUTO_CODE_MSB:AUTO_CODE_LSB] = cp_auto;
            end
            IDX_IRQ_STAT: begin
                rdata[IRQ_W-1:0] = irq_stat;
            end
            IDX_IRQ_MASK: begin
                rdata[IRQ_W-1:0] = irq_mask;
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

endmodule : scpc_clock_control

// ==== verification/scpc_clock_control_chk.sv ====
// Checker module with the port-level properties of the sample clock control block, bound to its top.
`timescale 1ns/100ps
module scpc_clock_control_chk #(
    parameter int DAC_CAL_CYCLES = 40,
    parameter int VCO_CAL_CYCLES = 16
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sample_clock_from_pll,
    input wire logic [7:0]  fb_divide,
    input wire logic [8:0]  pll_multiply,
    input wire logic [2:0]  cp_code,
    input wire logic [9:0]  charge_pump_current,
    input wire logic        vco_cal_busy,
    input wire logic        dac_cal_busy,
    input wire logic        irq
);
    int vco_run;
    int dac_run;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Busy run lengths are counted here because the repetition operator cannot hold them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) vco_run <= 0;
        else vco_run <= vco_cal_busy ? vco_run + 1 : 0;
    end

    // Same run counter for the converter calibration interval.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) dac_run <= 0;
        else dac_run <= dac_cal_busy ? dac_run + 1 : 0;
    end

    even_range_a: assert property (pll_multiply >= 9'd20 && !pll_multiply[0])
        else $error("multiplier odd or below twenty");
    div_floor_a: assert property (fb_divide >= 8'h0a)
        else $error("feedback divide below ten");
    mult_double_a: assert property ($stable(fb_divide) [*2] |-> pll_multiply == {fb_divide, 1'b0})
        else $error("multiplier is not twice the divide");
    cp_current_a: assert property ($stable(cp_code) [*2] |->
        charge_pump_current == ({7'h0, cp_code} + 10'd1) * 10'd125)
        else $error("charge pump current does not match code");
    vco_length_a: assert property ($fell(vco_cal_busy) |-> vco_run == VCO_CAL_CYCLES + 1)
        else $error("oscillator calibration length wrong");
    dac_length_a: assert property ($fell(dac_cal_busy) |-> dac_run == DAC_CAL_CYCLES + 1)
        else $error("converter calibration length wrong");
    cal_order_a: assert property (vco_cal_busy |-> !dac_cal_busy)
        else $error("both calibrations running together");
    vco_on_pll_a: assert property ($rose(vco_cal_busy) |-> sample_clock_from_pll)
        else $error("oscillator calibration without the loop selected");
    read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly one wait");
    read_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata) && !hresp)
        else $error("read data moved without a read answer");

    vco_cover_c: cover property ($fell(vco_cal_busy));
    dac_cover_c: cover property ($fell(dac_cal_busy));
    irq_cover_c: cover property ($rose(irq));
    read_cover_c: cover property (!hreadyout ##1 hreadyout);
endmodule : scpc_clock_control_chk

bind scpc_clock_control scpc_clock_control_chk #(
    .DAC_CAL_CYCLES(DAC_CAL_CYCLES),
    .VCO_CAL_CYCLES(VCO_CAL_CYCLES)
) scpc_clock_control_chk_i (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_clock_from_pll(sample_clock_from_pll),
    .fb_divide(fb_divide), .pll_multiply(pll_multiply), .cp_code(cp_code),
    .charge_pump_current(charge_pump_current), .vco_cal_busy(vco_cal_busy), .dac_cal_busy(dac_cal_busy),
    .irq(irq)
);

// ==== verification/scpc_pll_model.sv ====
// Behavioural model of the loop and reference source that drives the raw lock level.
`timescale 1ns/100ps
module scpc_pll_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pll_en,
    input  wire logic lose_lock,
    input  var  int   lock_delay,
    output logic      pll_lock_raw
);
    int settle;

    // Settling time restarts whenever the loop is deselected or the reference is disturbed.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) settle <= 0;
        else if (!pll_en || lose_lock) settle <= 0;
        else if (settle < lock_delay) settle <= settle + 1;
    end

    // Lock is only reported while the loop is the selected clock source and settled.
    assign pll_lock_raw = pll_en && !lose_lock && (settle >= lock_delay);
endmodule : scpc_pll_model

// ==== verification/scpc_clock_control_test.sv ====
// Self-checking testbench for the sample clock control block.
`timescale 1ns/100ps
module scpc_clock_control_test;
    import scpc_pkg::*;
    localparam int VCO_N = 16;
    localparam int DAC_N = 40;
    localparam logic [7:0] DIVS [8] = '{8'd10, 8'd255, 8'd16, 8'd100, 8'd37, 8'd44, 8'd63, 8'd80};

    logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, pll_lock_raw, lose_lock;
    logic        sample_clock_from_pll, vco_cal_busy, dac_cal_busy, irq;
    logic [1:0]  htrans;
    logic [2:0]  hsize, cp_code;
    logic [7:0]  fb_divide;
    logic [8:0]  pll_multiply;
    logic [9:0]  charge_pump_current;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_mismatch, samples_checked, cyc, lock_delay;

    // The one slave's ready is the bus ready.
    assign hready = hreadyout;

    scpc_clock_control #(.DAC_CAL_CYCLES(DAC_N), .VCO_CAL_CYCLES(VCO_N)) scpc_clock_control_i (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pll_lock_raw(pll_lock_raw), .sample_clock_from_pll(sample_clock_from_pll),
        .fb_divide(fb_divide), .pll_multiply(pll_multiply), .cp_code(cp_code),
        .charge_pump_current(charge_pump_current), .vco_cal_busy(vco_cal_busy),
        .dac_cal_busy(dac_cal_busy), .irq(irq)
    );

    scpc_pll_model scpc_pll_model_i (
        .clk(clk), .rst_b(rst_b), .pll_en(sample_clock_from_pll), .lose_lock(lose_lock),
        .lock_delay(lock_delay), .pll_lock_raw(pll_lock_raw)
    );

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Cycle ceiling so that a hung handshake still reaches the report.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One single word transfer; the address phase is held until ready, read data taken at the last edge.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
        int k;
        k = 0;
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        rdat = hrdata;
        if (k >= 50) chk("bus ready", 32'h1, 32'h0);
    endtask : bus

    // Bounded wait for a calibration busy level.
    task automatic wait_busy(input logic dac, input logic lvl);
        int k;
        k = 0;
        while (((dac ? dac_cal_busy : vco_cal_busy) !== lvl) && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k >= 200) chk("busy wait", {31'h0, lvl}, {31'h0, ~lvl});
    endtask : wait_busy

    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // Main sequence: reset values, manual current table, calibration order, lock and interrupts.
    initial begin
        rst_b = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2;
        hwdata = '0; lose_lock = 1'b0; lock_delay = 20; n_mismatch = 0; samples_checked = 0; cyc = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, IDX_CFG_THREE, 32'h0, rd);
        chk("cfg three reset", 32'h0000_1418, rd);
        chk("reset current", 32'd500, {22'h0, charge_pump_current});
        bus(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, IDX_CFG_THREE, {16'h0, DIVS[i], 2'b01, i[2:0], 3'h0}, rd);
            repeat (3) @(posedge clk);
            chk("divide", {24'h0, DIVS[i]}, {24'h0, fb_divide});
            chk("multiply", {23'h0, DIVS[i], 1'b0}, {23'h0, pll_multiply});
            chk("manual code", i, {29'h0, cp_code});
            chk("current", (i + 1) * 125, {22'h0, charge_pump_current});
            chk("direct path", 32'h0, {31'h0, sample_clock_from_pll});
        end
        bus(1'b1, IDX_CFG_THREE, 32'h0004_1918, rd);
        repeat (lock_delay + 8) @(posedge clk);
        chk("loop path", 32'h1, {31'h0, sample_clock_from_pll});
        bus(1'b0, IDX_STATUS, 32'h0, rd);
        chk("locked status", 32'h0100_0003, rd);
        chk("masked irq", 32'h0, {31'h0, irq});
        bus(1'b1, IDX_IRQ_MASK, 32'h7, rd);
        repeat (3) @(posedge clk);
        chk("unmasked irq", 32'h1, {31'h0, irq});
        bus(1'b1, IDX_IRQ_STAT, 32'h7, rd);
        repeat (3) @(posedge clk);
        chk("cleared irq", 32'h0, {31'h0, irq});
        bus(1'b1, IDX_CFG_ONE, 32'h0100_0000, rd);
        wait_busy(1'b0, 1'b1);
        wait_busy(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        chk("auto code", 32'h2, {29'h0, cp_code});
        chk("auto current", 32'd375, {22'h0, charge_pump_current});
        bus(1'b0, IDX_IRQ_STAT, 32'h0, rd);
        chk("vco done flag", 32'h1, rd);
        bus(1'b1, IDX_IRQ_STAT, 32'h1, rd);
        bus(1'b1, IDX_CFG_ONE, 32'h0100_0000, rd);
        repeat (4) @(posedge clk);
        chk("retrigger ignored", 32'h0, {31'h0, vco_cal_busy});
        bus(1'b1, IDX_CFG_ONE, 32'h0, rd);
        bus(1'b1, IDX_CFG_ONE, 32'h0100_0000, rd);
        bus(1'b1, IDX_CFG_FOUR, 32'h0100_0000, rd);
        wait_busy(1'b0, 1'b1);
        chk("dac held", 32'h0, {31'h0, dac_cal_busy});
        wait_busy(1'b0, 1'b0);
        wait_busy(1'b1, 1'b1);
        wait_busy(1'b1, 1'b0);
        bus(1'b1, IDX_CFG_FOUR, 32'h0, rd);
        bus(1'b0, IDX_IRQ_STAT, 32'h0, rd);
        chk("both done flags", 32'h3, rd);
        bus(1'b1, IDX_STATUS, 32'h0, rd);
        bus(1'b0, IDX_STATUS, 32'h0, rd);
        chk("status read only", 32'h0100_0002, rd);
        lose_lock <= 1'b1;
        repeat (6) @(posedge clk);
        bus(1'b0, IDX_STATUS, 32'h0, rd);
        chk("lock lost", 32'h0000_0002, rd);
        lose_lock <= 1'b0;
        bus(1'b1, IDX_CFG_THREE, 32'h0000_1918, rd);
        repeat (lock_delay + 8) @(posedge clk);
        chk("back to direct", 32'h0, {31'h0, sample_clock_from_pll});
        bus(1'b0, IDX_STATUS, 32'h0, rd);
        chk("no lock direct", 32'h0000_0002, rd);
        test_done();
    end
endmodule : scpc_clock_control_test
